// file: common/dflg_defines.vh
/*
 * Constants of the diagnostic flag bank: register indexes, flag bit
 * positions, reset values and widths.
 * Assumes: included by bare name from the rtl files; definitions only.
 */
`ifndef DFLG_DEFINES_VH
`define DFLG_DEFINES_VH

// ****************************************************************
// Widths
// ****************************************************************
`define DFLG_SW 16
`define DFLG_NCMP 11
`define DFLG_AW 12

// ****************************************************************
// Register indexes (byte address = 4 * index)
// ****************************************************************
`define DFLG_IDX_THR_END 10'h00B
`define DFLG_IDX_TXALM 10'h070
`define DFLG_IDX_RXALM 10'h071
`define DFLG_IDX_WARN 10'h074
`define DFLG_IDX_STAT 10'h078
`define DFLG_IDX_CLR 10'h079
`define DFLG_IDX_EN 10'h07A
`define DFLG_IDX_CNT 10'h07B
`define DFLG_IDX_CTRL 10'h07C
`define DFLG_IDX_S_TEMP 10'h080
`define DFLG_IDX_S_VCC 10'h081
`define DFLG_IDX_S_BIAS 10'h082
`define DFLG_IDX_S_TXP 10'h083
`define DFLG_IDX_S_RXP 10'h084

// ****************************************************************
// Comparator slots (also status, clear and enable bit positions)
// ****************************************************************
`define DFLG_F_BIAS_HA 0
`define DFLG_F_BIAS_LA 1
`define DFLG_F_TXP_HA 2
`define DFLG_F_TXP_LA 3
`define DFLG_F_RXP_HA 4
`define DFLG_F_RXP_LA 5
`define DFLG_F_TEMP_HW 6
`define DFLG_F_TEMP_LW 7
`define DFLG_F_VCC_HW 8
`define DFLG_F_VCC_LW 9
`define DFLG_F_BIAS_HW 10

// ****************************************************************
// Bit positions in the flag bytes and the control register
// ****************************************************************
`define DFLG_TXA_BIAS_HI 3
`define DFLG_TXA_BIAS_LO 2
`define DFLG_TXA_TXP_HI 1
`define DFLG_TXA_TXP_LO 0
`define DFLG_RXA_RXP_HI 7
`define DFLG_RXA_RXP_LO 6
`define DFLG_WRN_TEMP_HI 7
`define DFLG_WRN_TEMP_LO 6
`define DFLG_WRN_VCC_HI 5
`define DFLG_WRN_VCC_LO 4
`define DFLG_WRN_BIAS_HI 3
`define DFLG_CTRL_RUN 0

// ****************************************************************
// Reset values
// ****************************************************************
`define DFLG_THR_HI_RST 16'hFFFF
`define DFLG_THR_LO_RST 16'h0000
`define DFLG_EN_RST 11'h000
`define DFLG_CTRL_RST 1'b1

`endif

// file: rtl/dflg_cmp.v
/*
 * One threshold comparator of the flag bank.
 * Assumes: sample and threshold are unsigned and share one clock.
 */
`timescale 1ns/1ps

module dflg_cmp #(
    parameter SW = 16,
    parameter HIGH = 1
) (
    input wire [SW-1:0] sample, // Measured value
    input wire [SW-1:0] thresh, // Programmed threshold
    output wire hit // Threshold passed
);

// ****************************************************************
// Compare
// ****************************************************************
// Strict compare: a sample equal to the threshold raises nothing
generate
    if (HIGH != 0) begin : g_high
        assign hit = (sample > thresh);
    end else begin : g_low
        assign hit = (sample < thresh);
    end
endgenerate

endmodule // dflg_cmp

// file: rtl/dflg_irq.v
/*
 * Sticky event status, write-one-to-clear, enable mask and level irq.
 * Assumes: all inputs come from logic on pclk.
 */
`timescale 1ns/1ps
`include "dflg_defines.vh"

module dflg_irq #(
    parameter N = 11
) (
    input wire pclk, // Clock
    input wire presetn, // Async reset, active low
    input wire [N-1:0] evt, // One-cycle event pulses
    input wire clr_wr, // Clear register written
    input wire en_wr, // Enable register written
    input wire [N-1:0] wdata, // Write data
    output wire [N-1:0] status, // Sticky status
    output wire [N-1:0] enable, // Enable mask
    output wire irq // Level interrupt, active high
);

reg [N-1:0] status_ff;
reg [N-1:0] enable_ff;
reg irq_ff;
reg [N-1:0] nxt_status;
reg [N-1:0] nxt_enable;

// ****************************************************************
// Next state
// ****************************************************************
always @* begin
    // Set wins over a clear in the same cycle
    nxt_status = evt | (status_ff & ~(clr_wr ? wdata : {N{1'b0}}));
    nxt_enable = en_wr ? wdata : enable_ff;
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        status_ff <= {N{1'b0}};
        enable_ff <= `DFLG_EN_RST;
        irq_ff <= 1'b0;
    end else begin
        status_ff <= nxt_status;
        enable_ff <= nxt_enable;
        irq_ff <= |(nxt_status & nxt_enable);
    end
end

assign status = status_ff;
assign enable = enable_ff;
assign irq = irq_ff;

endmodule // dflg_irq

// file: rtl/dflg_top.v
/*
 * Diagnostic alarm and warning flag bank of an optical module, with
 * threshold registers, sample readback and an interrupt, over APB.
 * Assumes: smp_* and smp_valid come from the monitor on pclk; the APB
 * master keeps the standard setup and access phases.
 */
// Functional notes
// RULE1 - Tx alarm bit 3: bias above high alarm
// RULE2 - Tx alarm bit 2: bias below low alarm
// RULE3 - Tx alarm bit 1: tx power above high
// RULE4 - Tx alarm bit 0: tx power below low
// RULE5 - Byte 0x71 bit 7: rx power above high
// RULE6 - Byte 0x71 bit 6: rx power below low
// RULE7 - Byte 0x71 bits 0-5 carry no flag
// RULE8 - Byte 0x74 bit 7: temperature above high warning
// RULE9 - Byte 0x74 bit 6 is temperature low warning
// RULE10 - Temperature low warning: below low threshold
// RULE11 - Byte 0x74 bit 5: supply above high warning
// RULE12 - Byte 0x74 bit 4: supply below low warning
// RULE13 - Byte 0x74 bit 3: bias above high warning
// RULE14 - Flags recomputed per sample; reserved read zero (samples are ignored while run is low)
`timescale 1ns/1ps
`include "dflg_defines.vh"

module dflg_top #(
    parameter SW = `DFLG_SW,
    parameter AW = `DFLG_AW
) (
    input wire pclk, // APB clock, 40 MHz
    input wire presetn, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB access phase
    input wire pwrite, // APB direction, high for write
    input wire [AW-1:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output wire [31:0] prdata, // APB read data
    output wire pready, // APB ready
    output wire pslverr, // APB error
    input wire smp_valid, // New monitor sample, one cycle
    input wire [SW-1:0] smp_temp, // Internal temperature
    input wire [SW-1:0] smp_vcc, // Supply voltage
    input wire [SW-1:0] smp_bias, // Laser bias current
    input wire [SW-1:0] smp_txpwr, // Transmit optical power
    input wire [SW-1:0] smp_rxpwr, // Receive optical power
    output wire irq // Interrupt, active high level
);

localparam NC = `DFLG_NCMP;

// ****************************************************************
// Declarations
// ****************************************************************
wire [9:0] idx;
wire aligned;
wire setup;
wire access;
wire wr_ok;
wire run;
wire smp_take;
wire [NC*SW-1:0] smp_bus;
wire [NC*SW-1:0] thr_bus;
wire [NC-1:0] hit;
wire [NC-1:0] evt;
wire [NC-1:0] status;
wire [NC-1:0] enable;
wire clr_wr;
wire en_wr;
reg [NC-1:0] flag_ff;
reg [NC-1:0] nxt_flag;
reg [SW-1:0] temp_ff;
reg [SW-1:0] vcc_ff;
reg [SW-1:0] bias_ff;
reg [SW-1:0] txp_ff;
reg [SW-1:0] rxp_ff;
reg [15:0] cnt_ff;
reg ctrl_ff;
reg [31:0] rdata_ff;
reg err_ff;
reg [31:0] nxt_rdata;
reg nxt_err;
reg [7:0] txa_byte;
reg [7:0] rxa_byte;
reg [7:0] wrn_byte;
integer i;

// ****************************************************************
// Decode helpers
// ****************************************************************
function is_thr;
    input [9:0] i_idx;
    begin
        is_thr = (i_idx < `DFLG_IDX_THR_END);
    end
endfunction

function is_rw;
    input [9:0] i_idx;
    begin
        is_rw = is_thr(i_idx) || (i_idx == `DFLG_IDX_CLR) ||
                (i_idx == `DFLG_IDX_EN) || (i_idx == `DFLG_IDX_CTRL);
    end
endfunction

// Even slots test a high limit, odd slots a low one
function slot_high;
    input integer slot;
    begin
        slot_high = ((slot % 2) == 0);
    end
endfunction

// ****************************************************************
// APB phase decode
// ****************************************************************
assign idx = paddr[11:2];
assign aligned = (paddr[1:0] == 2'b00);
assign setup = psel & ~penable;
assign access = psel & penable;
// Zero wait states: every access completes in its first access cycle
assign pready = access;
assign wr_ok = access & pwrite & aligned;
assign clr_wr = wr_ok & (idx == `DFLG_IDX_CLR);
assign en_wr = wr_ok & (idx == `DFLG_IDX_EN);
assign run = ctrl_ff;
// RULE14 samples count only while running
assign smp_take = smp_valid & run;

// ****************************************************************
// Control register
// ****************************************************************
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_ff <= `DFLG_CTRL_RST;
    end else if (wr_ok && idx == `DFLG_IDX_CTRL) begin
        ctrl_ff <= pwdata[`DFLG_CTRL_RUN];
    end
end

// ****************************************************************
// Sample routing to comparator slots
// ****************************************************************
// Each slot placed by its flag position; compare direction and reset value still follow slot parity
assign smp_bus[`DFLG_F_BIAS_HA*SW +: SW] = smp_bias;
assign smp_bus[`DFLG_F_BIAS_LA*SW +: SW] = smp_bias;
assign smp_bus[`DFLG_F_TXP_HA*SW +: SW] = smp_txpwr;
assign smp_bus[`DFLG_F_TXP_LA*SW +: SW] = smp_txpwr;
assign smp_bus[`DFLG_F_RXP_HA*SW +: SW] = smp_rxpwr;
assign smp_bus[`DFLG_F_RXP_LA*SW +: SW] = smp_rxpwr;
assign smp_bus[`DFLG_F_TEMP_HW*SW +: SW] = smp_temp;
assign smp_bus[`DFLG_F_TEMP_LW*SW +: SW] = smp_temp;
assign smp_bus[`DFLG_F_VCC_HW*SW +: SW] = smp_vcc;
assign smp_bus[`DFLG_F_VCC_LW*SW +: SW] = smp_vcc;
assign smp_bus[`DFLG_F_BIAS_HW*SW +: SW] = smp_bias;

// ****************************************************************
// Threshold registers and comparators
// ****************************************************************
genvar k;
generate
    for (k = 0; k < NC; k = k + 1) begin : g_slot
        localparam [9:0] KI = k;
        localparam [SW-1:0] RST = slot_high(k) ?
            `DFLG_THR_HI_RST : `DFLG_THR_LO_RST;
        localparam HI = slot_high(k) ? 1 : 0;
        reg [SW-1:0] thr_ff;

        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                thr_ff <= RST;
            end else if (wr_ok && idx == KI) begin
                thr_ff <= pwdata[SW-1:0];
            end
        end

        assign thr_bus[k*SW +: SW] = thr_ff;

        // RULE14 sample against threshold
        dflg_cmp #(
            .SW(SW),
            .HIGH(HI)
        ) u_cmp (
            .sample(smp_bus[k*SW +: SW]),
            .thresh(thr_ff),
            .hit(hit[k])
        );
    end
endgenerate

// ****************************************************************
// Flag state
// ****************************************************************
always @* begin
    nxt_flag = flag_ff;
    // RULE14 refresh on each sample taken while run is high
    if (smp_take) begin
        nxt_flag = hit;
    end
end

// Rising flags become interrupt events
assign evt = nxt_flag & ~flag_ff;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        flag_ff <= {NC{1'b0}};
    end else begin
        flag_ff <= nxt_flag;
    end
end

// ****************************************************************
// Sample readback and count
// ****************************************************************
// Frozen with the flags while run is low
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        temp_ff <= {SW{1'b0}};
        vcc_ff <= {SW{1'b0}};
        bias_ff <= {SW{1'b0}};
        txp_ff <= {SW{1'b0}};
        rxp_ff <= {SW{1'b0}};
        cnt_ff <= 16'h0000;
    end else if (smp_take) begin
        temp_ff <= smp_temp;
        vcc_ff <= smp_vcc;
        bias_ff <= smp_bias;
        txp_ff <= smp_txpwr;
        rxp_ff <= smp_rxpwr;
        // Wraps; software takes differences
        cnt_ff <= cnt_ff + 16'h0001;
    end
end

// ****************************************************************
// Flag bytes
// ****************************************************************
always @* begin
    txa_byte = 8'h00;
    rxa_byte = 8'h00;
    wrn_byte = 8'h00;
    // RULE1 bias high alarm
    txa_byte[`DFLG_TXA_BIAS_HI] = flag_ff[`DFLG_F_BIAS_HA];
    // RULE2 bias low alarm
    txa_byte[`DFLG_TXA_BIAS_LO] = flag_ff[`DFLG_F_BIAS_LA];
    // RULE3 power high alarm
    txa_byte[`DFLG_TXA_TXP_HI] = flag_ff[`DFLG_F_TXP_HA];
    // RULE4 power low alarm
    txa_byte[`DFLG_TXA_TXP_LO] = flag_ff[`DFLG_F_TXP_LA];
    // RULE5 rx high alarm
    rxa_byte[`DFLG_RXA_RXP_HI] = flag_ff[`DFLG_F_RXP_HA];
    // RULE6 rx low alarm
    rxa_byte[`DFLG_RXA_RXP_LO] = flag_ff[`DFLG_F_RXP_LA];
    // RULE7 low six stay zero
    rxa_byte[5:0] = 6'h00;
    // RULE8 temperature high warning
    wrn_byte[`DFLG_WRN_TEMP_HI] = flag_ff[`DFLG_F_TEMP_HW];
    // RULE9 RULE10 temperature low warning
    wrn_byte[`DFLG_WRN_TEMP_LO] = flag_ff[`DFLG_F_TEMP_LW];
    // RULE11 supply high warning
    wrn_byte[`DFLG_WRN_VCC_HI] = flag_ff[`DFLG_F_VCC_HW];
    // RULE12 supply low warning
    wrn_byte[`DFLG_WRN_VCC_LO] = flag_ff[`DFLG_F_VCC_LW];
    // RULE13 bias high warning
    wrn_byte[`DFLG_WRN_BIAS_HI] = flag_ff[`DFLG_F_BIAS_HW];
end

// ****************************************************************
// Interrupt status, clear and enable
// ****************************************************************
dflg_irq #(
    .N(NC)
) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .evt(evt),
    .clr_wr(clr_wr),
    .en_wr(en_wr),
    .wdata(pwdata[NC-1:0]),
    .status(status),
    .enable(enable),
    .irq(irq)
);

// ****************************************************************
// Read mux and error decode
// ****************************************************************
// Evaluated in the setup cycle so read data leaves a flip-flop;
// a flag that changes during the access shows on the next read
always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_err = 1'b0;
    if (!aligned) begin
        nxt_err = 1'b1;
    end else if (is_thr(idx)) begin
        for (i = 0; i < NC; i = i + 1) begin
            if (idx == i[9:0]) begin
                nxt_rdata[SW-1:0] = thr_bus[i*SW +: SW];
            end
        end
    end else begin
        case (idx)
            `DFLG_IDX_TXALM: nxt_rdata[7:0] = txa_byte;
            `DFLG_IDX_RXALM: nxt_rdata[7:0] = rxa_byte;
            `DFLG_IDX_WARN: nxt_rdata[7:0] = wrn_byte;
            `DFLG_IDX_STAT: nxt_rdata[NC-1:0] = status;
            `DFLG_IDX_CLR: nxt_rdata = 32'h0000_0000;
            `DFLG_IDX_EN: nxt_rdata[NC-1:0] = enable;
            `DFLG_IDX_CNT: nxt_rdata[15:0] = cnt_ff;
            `DFLG_IDX_CTRL: nxt_rdata[`DFLG_CTRL_RUN] = ctrl_ff;
            `DFLG_IDX_S_TEMP: nxt_rdata[SW-1:0] = temp_ff;
            `DFLG_IDX_S_VCC: nxt_rdata[SW-1:0] = vcc_ff;
            `DFLG_IDX_S_BIAS: nxt_rdata[SW-1:0] = bias_ff;
            `DFLG_IDX_S_TXP: nxt_rdata[SW-1:0] = txp_ff;
            `DFLG_IDX_S_RXP: nxt_rdata[SW-1:0] = rxp_ff;
            default: nxt_err = 1'b1;
        endcase
        // Writes to read-only words are dropped and flagged
        if (pwrite && !nxt_err && !is_rw(idx)) begin
            nxt_err = 1'b1;
        end
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rdata_ff <= 32'h0000_0000;
    end else if (setup) begin
        // Writes return zero so stale read data never leaks
        rdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        err_ff <= 1'b0;
    end else if (setup) begin
        err_ff <= nxt_err;
    end
end

assign prdata = rdata_ff;
assign pslverr = access & err_ff;

endmodule // dflg_top

// file: tb/dflg_top_properties.sv
/* Checker bound to dflg_top: mirrors thresholds, run bit and flags.
   Assumes: threshold writes and samples never share an edge. */
`timescale 1ns/1ps
module dflg_props #(
    parameter SW = 16,
    parameter AW = 12
) (
    input wire pclk, // Clock
    input wire presetn, // Reset, active low
    input wire psel, // Select
    input wire penable, // Access
    input wire pwrite, // Write
    input wire [AW-1:0] paddr, // Address
    input wire [31:0] pwdata, // Write data
    input wire [31:0] prdata, // Read data
    input wire pready, // Ready
    input wire pslverr, // Error
    input wire smp_valid, // Sample strobe
    input wire [SW-1:0] smp_temp, // Temperature
    input wire [SW-1:0] smp_vcc, // Supply
    input wire [SW-1:0] smp_bias, // Bias
    input wire [SW-1:0] smp_txpwr, // Tx power
    input wire [SW-1:0] smp_rxpwr, // Rx power
    input wire irq // Interrupt
);
    logic [SW-1:0] thr [0:10];
    logic [SW-1:0] src [0:10];
    logic [10:0] cmp;
    logic [10:0] hit_ff;
    logic [10:0] flg;
    logic run_ff;
    wire wr = psel && penable && pwrite && paddr[1:0] == 2'h0;
    wire rd = psel && penable && !pwrite;
    wire rtx = rd && paddr == 12'h1C0;
    wire rrx = rd && paddr == 12'h1C4;
    wire rwn = rd && paddr == 12'h1D0;
    assign src = '{smp_bias, smp_bias, smp_txpwr, smp_txpwr, smp_rxpwr,
        smp_rxpwr, smp_temp, smp_temp, smp_vcc, smp_vcc, smp_bias};
    // Even slots are high limits, odd slots low limits
    always_comb begin
        for (int i = 0; i < 11; i++) begin
            cmp[i] = (i % 2 == 0) ? src[i] > thr[i] : src[i] < thr[i];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 11; i++) begin
                thr[i] <= (i % 2 == 0) ? 16'hFFFF : 16'h0000;
            end
            hit_ff <= 11'h000;
            flg <= 11'h000;
            run_ff <= 1'b1;
        end else begin
            if (wr && paddr[AW-1:2] < 11) begin
                thr[paddr[AW-1:2]] <= pwdata[SW-1:0];
            end
            if (wr && paddr == 12'h1F0) begin
                run_ff <= pwdata[0];
            end
            if (smp_valid && run_ff) begin
                flg <= cmp;
            end
            // Read data is frozen in the setup cycle
            if (psel && !penable) begin
                hit_ff <= flg;
            end
        end
    end
    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_bias_hi_alarm: assert property (rtx |-> prdata[3] == hit_ff[0])
        else $error("bias high alarm bit wrong");
    a_bias_lo_alarm: assert property (rtx |-> prdata[2] == hit_ff[1])
        else $error("bias low alarm bit wrong");
    a_txp_alarms: assert property
        (rtx |-> prdata[1:0] == {hit_ff[2], hit_ff[3]})
        else $error("tx power alarm bits wrong");
    a_rxp_alarms: assert property
        (rrx |-> prdata[7:6] == {hit_ff[4], hit_ff[5]})
        else $error("rx power alarm bits wrong");
    a_rx_reserved: assert property (rrx |-> prdata[5:0] == 6'h00)
        else $error("rx byte reserved bits set");
    a_temp_warn: assert property
        (rwn |-> prdata[7:6] == {hit_ff[6], hit_ff[7]})
        else $error("temperature warning bits wrong");
    a_vcc_warn: assert property
        (rwn |-> prdata[5:4] == {hit_ff[8], hit_ff[9]})
        else $error("supply warning bits wrong");
    a_bias_hi_warn: assert property (rwn |-> prdata[3] == hit_ff[10])
        else $error("bias high warning bit wrong");
    a_unused_zero: assert property
        (rwn |-> prdata[2:0] == 3'h0 && prdata[31:8] == 24'h000000)
        else $error("warning byte spare bits set");
    a_irq_cause: assert property
        ($rose(irq) |-> $past(smp_valid || (psel && penable && pwrite)))
        else $error("irq rose without sample or write");
    a_irq_drop: assert property ($fell(irq) |-> $past(wr))
        else $error("irq fell without a write");
    a_bad_align: assert property
        (psel && penable && paddr[1:0] != 2'h0 |-> pslverr && pready)
        else $error("unaligned access not refused");
    c_tx_flag: cover property (rtx && prdata[3]);
    c_irq: cover property ($rose(irq));
    c_err: cover property (pslverr);
endmodule // dflg_props

bind dflg_top dflg_props #(.SW(SW), .AW(AW)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .smp_valid(smp_valid),
    .smp_temp(smp_temp), .smp_vcc(smp_vcc), .smp_bias(smp_bias),
    .smp_txpwr(smp_txpwr), .smp_rxpwr(smp_rxpwr), .irq(irq)
);

// file: tb/dflg_apb_host.sv
/* Management host model: an APB master with one transfer task.
   Assumes: the bench calls xfer only from one process at a time. */
`timescale 1ns/1ps
module dflg_apb_host #(
    parameter AW = 12
) (
    input wire pclk, // Clock
    output logic psel = 1'b0, // Select
    output logic penable = 1'b0, // Access
    output logic pwrite = 1'b0, // Write
    output logic [AW-1:0] paddr = '0, // Address
    output logic [31:0] pwdata = '0, // Write data
    input wire [31:0] prdata, // Read data
    input wire pready, // Ready
    input wire pslverr // Error
);
    // Request held until pready is seen, bounded so a hang ends
    task automatic xfer(input logic w, input logic [AW-1:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e,
        output logic hung);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        hung = (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // dflg_apb_host

// file: tb/dflg_top_tb.sv
/* Self-checking bench of the flag bank against a queue-free model.
   Assumes: the host model drives APB; the bench drives samples. */
`timescale 1ns/1ps
`define CHK(g, e) cmp32(32'(g), 32'(e))
module dflg_top_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic smp_valid = 1'b0;
    logic [15:0] smp_temp = '0, smp_vcc = '0, smp_bias = '0;
    logic [15:0] smp_txpwr = '0, smp_rxpwr = '0;
    int fail_count = 0;
    int n_compared = 0;
    int thr [11];
    bit run = 1'b1;
    logic [10:0] mhit = '0, mstat = '0, men = '0;
    int mcnt = 0;
    int mlast [5] = '{0, 0, 0, 0, 0};
    logic [31:0] rs = 32'h0000005F;
    dflg_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .smp_valid(smp_valid),
        .smp_temp(smp_temp), .smp_vcc(smp_vcc), .smp_bias(smp_bias),
        .smp_txpwr(smp_txpwr), .smp_rxpwr(smp_rxpwr), .irq(irq)
    );
    dflg_apb_host host (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr)
    );
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    function int rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs & 32'h0000FFFF;
    endfunction
    task automatic close_out();
        $display("compared %0d wrong %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e, h;
        host.xfer(w, a, d, r, e, h);
        if (h) begin
            fail_count++;
            close_out();
        end
        if (!w) begin
            `CHK(r, x);
        end
        `CHK(e, xe);
    endtask
    task automatic sample(input int b, tx, rx, t, v);
        int s [11];
        @(posedge pclk);
        smp_valid <= 1'b1;
        {smp_bias, smp_txpwr, smp_rxpwr} <= {b[15:0], tx[15:0], rx[15:0]};
        {smp_temp, smp_vcc} <= {t[15:0], v[15:0]};
        @(posedge pclk);
        smp_valid <= 1'b0;
        s = '{b, b, tx, tx, rx, rx, t, t, v, v, b};
        for (int i = 0; i < 11 && run; i++) begin
            mstat[i] |= (i % 2 == 0 ? s[i] > thr[i] : s[i] < thr[i])
                && !mhit[i];
            mhit[i] = i % 2 == 0 ? s[i] > thr[i] : s[i] < thr[i];
        end
        if (run) begin
            mcnt++;
            mlast = '{t, v, b, tx, rx};
        end
    endtask
    task automatic check_all();
        acc(0, 12'h1C0, 0, {mhit[0], mhit[1], mhit[2], mhit[3]}, 0);
        acc(0, 12'h1C4, 0, {mhit[4], mhit[5], 6'h00}, 0);
        acc(0, 12'h1D0, 0, {mhit[6], mhit[7], mhit[8], mhit[9],
            mhit[10], 3'h0}, 0);
        acc(0, 12'h1E0, 0, {21'h000000, mstat}, 0);
        acc(0, 12'h1E8, 0, men, 0);
        acc(0, 12'h1EC, 0, mcnt, 0);
        acc(0, 12'h1F0, 0, run, 0);
        for (int i = 0; i < 5; i++) begin
            acc(0, 12'(12'h200 + i * 4), 0, mlast[i], 0);
        end
        `CHK(irq, |(mstat & men));
    endtask
    initial begin
        presetn = 1'b0;
        for (int i = 0; i < 11; i++) begin
            thr[i] = i % 2 == 0 ? 32'h0000FFFF : 32'h00000000;
        end
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            acc(0, 12'(i * 4), 0, thr[i], 0);
        end
        check_all();
        for (int i = 0; i < 11; i++) begin
            thr[i] = rnd();
            acc(1, 12'(i * 4), thr[i], 0, 0);
        end
        men = 11'h7FF;
        acc(1, 12'h1E8, 32'h000007FF, 0, 0);
        // Every fourth sample sits exactly on the high limits of slots 0 to 8
        for (int k = 0; k < 24; k++) begin
            if (k % 4 == 0) begin
                sample(thr[0], thr[2], thr[4], thr[6], thr[8]);
            end else begin
                sample(rnd(), rnd(), rnd(), rnd(), rnd());
            end
            check_all();
        end
        acc(1, 12'h1E4, {21'h000000, mstat}, 0, 0);
        mstat = '0;
        check_all();
        men = '0;
        acc(1, 12'h1E8, 0, 0, 0);
        thr[0] = 0;
        acc(1, 12'h000, 0, 0, 0);
        sample(0, 0, 0, 0, 0);
        sample(32'h0000FFFF, 0, 0, 0, 0);
        check_all();
        men = 11'h001;
        acc(1, 12'h1E8, 32'h00000001, 0, 0);
        check_all();
        mstat[0] = 1'b0;
        acc(1, 12'h1E4, 32'h00000001, 0, 0);
        check_all();
        run = 1'b0;
        acc(1, 12'h1F0, 0, 0, 0);
        sample(0, 32'h0000FFFF, 0, 32'h0000FFFF, 0);
        check_all();
        run = 1'b1;
        acc(1, 12'h1F0, 32'h00000001, 0, 0);
        acc(0, 12'h1C5, 0, 0, 1);
        acc(0, 12'h3FC, 0, 0, 1);
        acc(1, 12'h1C4, 32'h0000003F, 0, 1);
        check_all();
        close_out();
    end
endmodule // dflg_top_tb
